// ---- sefe_pkg.sv ----
package sefe_pkg;
    localparam int          SEFE_BYTE_BITS  = 8;
    localparam int          SEFE_PAGES      = 32;
    localparam int          SEFE_PAGE_BYTES = 16;
    localparam int          SEFE_ADDR_W     = $clog2(SEFE_PAGES * SEFE_PAGE_BYTES);
    localparam logic [3:0]  SEFE_BIT_CNT_RST = 4'h0;
    localparam logic [3:0]  SEFE_ACK_SLOT   = 4'h8;
    localparam int          SEFE_TYPE_MSB   = 7;
    localparam int          SEFE_TYPE_LSB   = 4;
    localparam int          SEFE_SEL_HI_BIT = 3;
    localparam int          SEFE_SEL_LO_BIT = 2;
    localparam int          SEFE_MSB_BIT    = 1;
    localparam int          SEFE_RW_BIT     = 0;
    localparam logic [7:0]  SEFE_BYTE_RST   = 8'h00;
    localparam logic [8:0]  SEFE_WADDR_RST  = 9'h000;
    typedef enum logic [2:0] {
        SEFE_IDLE,
        SEFE_DEV,
        SEFE_WORD,
        SEFE_WDATA,
        SEFE_RDATA,
        SEFE_IGNORE
    } sefe_state_t;
endpackage

// ---- sefe_sync_if.sv ----
`timescale 1ns/1ps
// synchronised bus levels handed from the sampler to the protocol engine
interface sefe_sync_if;
    logic scl;
    logic sda;
    modport src (output scl, output sda);
    modport dst (input scl, input sda);
endinterface

// ---- sefe_sync.sv ----
`timescale 1ns/1ps
// two-flop synchroniser for the bus pins, clocked by the link clock
module sefe_sync (
    input  wire logic i_clk,
    input  wire logic i_resetn,
    input  wire logic i_scl,
    input  wire logic i_sda,
    sefe_sync_if.src  sync
);
    logic [1:0] scl_ff;
    logic [1:0] sda_ff;

    // idle bus reads high, so reset to one avoids a false Start
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            scl_ff <= 2'h3;
            sda_ff <= 2'h3;
        end else begin
            scl_ff <= {scl_ff[0], i_scl};
            sda_ff <= {sda_ff[0], i_sda};
        end
    end

    assign sync.scl = scl_ff[1];
    assign sync.sda = sda_ff[1];
endmodule

// ---- sefe_top.sv ----
`timescale 1ns/1ps
// two-wire target front end of a serial EEPROM
module sefe_top
    import sefe_pkg::*;
#(
    parameter logic [3:0] TYPE_ID = 4'h5 // arbitrary identifier value
) (
    input  wire logic                         i_clk,
    input  wire logic                         i_resetn,
    input  wire logic                         i_link_clk,
    input  wire logic                         i_scl,
    input  wire logic                         i_sda,
    output logic                              o_sda_out,
    output logic                              o_sda_oe,
    input  wire logic                         i_hw_select_hi,
    input  wire logic                         i_hw_select_lo,
    input  wire logic                         i_write_busy,
    input  wire logic [sefe_pkg::SEFE_BYTE_BITS-1:0] i_rd_data,
    output logic [sefe_pkg::SEFE_ADDR_W-1:0]  o_word_addr,
    output logic                              o_read_sel,
    output logic [sefe_pkg::SEFE_BYTE_BITS-1:0] o_wr_data,
    output logic                              o_wr_toggle,
    output logic                              o_rd_toggle,
    output logic                              o_stop_toggle,
    output logic                              o_standby
);
    import sefe_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // link-side sampling
    sefe_sync_if sy ();

    sefe_sync u_sync (
        .i_clk    (i_link_clk),
        .i_resetn (i_resetn),
        .i_scl    (i_scl),
        .i_sda    (i_sda),
        .sync     (sy.src)
    );

    // note: link clock must run freely and fast against SCL for oversampling
    logic scl_d_ff;
    logic sda_d_ff;
    always_ff @(posedge i_link_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            scl_d_ff <= 1'b1;
            sda_d_ff <= 1'b1;
        end else begin
            scl_d_ff <= sy.scl;
            sda_d_ff <= sy.sda;
        end
    end

    wire scl_rise = sy.scl & ~scl_d_ff;
    wire scl_fall = ~sy.scl & scl_d_ff;
    wire start_ev = scl_d_ff & sy.scl & sda_d_ff & ~sy.sda;
    wire stop_ev  = scl_d_ff & sy.scl & ~sda_d_ff & sy.sda;

    ////////////////////////////////////////////////////////////////////
    // busy level from the core domain, two flops before use
    logic [1:0] busy_sync_ff;
    always_ff @(posedge i_link_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            busy_sync_ff <= 2'h0;
        end else begin
            busy_sync_ff <= {busy_sync_ff[0], i_write_busy};
        end
    end
    wire busy_l = busy_sync_ff[1];

    // select pins are straps from outside; float resolves low at the pad
    logic [1:0] sel_hi_ff;
    logic [1:0] sel_lo_ff;
    always_ff @(posedge i_link_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            sel_hi_ff <= 2'h0;
            sel_lo_ff <= 2'h0;
        end else begin
            sel_hi_ff <= {sel_hi_ff[0], i_hw_select_hi};
            sel_lo_ff <= {sel_lo_ff[0], i_hw_select_lo};
        end
    end

    ////////////////////////////////////////////////////////////////////
    // protocol engine
    sefe_state_t                 state_ff;
    sefe_state_t                 nxt_state;
    logic [3:0]                  bit_cnt_ff;
    logic [SEFE_BYTE_BITS-1:0]   shift_ff;
    logic [SEFE_BYTE_BITS-1:0]   tx_ff;
    logic [SEFE_ADDR_W-1:0]      waddr_ff;
    logic                        rw_ff;
    logic                        sda_low_ff;
    logic                        standby_ff;
    logic                        wr_tog_ff;
    logic                        rd_tog_ff;
    logic                        stop_tog_ff;
    logic [SEFE_BYTE_BITS-1:0]   wdata_ff;
    logic                        data_seen_ff;
    logic                        master_ack_ff;
    logic                        fresh_ff;
    logic                        addr_hit_ff;

    wire in_ack    = (bit_cnt_ff == SEFE_ACK_SLOT);
    wire [SEFE_BYTE_BITS-1:0] rx_byte = {shift_ff[SEFE_BYTE_BITS-2:0], sy.sda};
    wire id_match  = (shift_ff[SEFE_TYPE_MSB-1:SEFE_TYPE_LSB-1] == TYPE_ID);
    wire sel_match = (shift_ff[SEFE_SEL_HI_BIT-1] == sel_hi_ff[1]) &&
                     (shift_ff[SEFE_SEL_LO_BIT-1] == sel_lo_ff[1]);
    wire addr_ok   = id_match && sel_match && !busy_l;
    wire byte_done = scl_rise && (bit_cnt_ff == SEFE_ACK_SLOT - 4'h1);

    // state transitions at byte boundaries; shifted byte holds seven bits at decision
    always_comb begin
        nxt_state = state_ff;
        if (start_ev) begin
            nxt_state = SEFE_DEV;
        end else if (stop_ev) begin
            nxt_state = SEFE_IDLE;
        end else if (scl_fall && in_ack) begin
            case (state_ff)
                SEFE_DEV:   nxt_state = !sda_low_ff ? SEFE_IGNORE :
                                        (rw_ff ? SEFE_RDATA : SEFE_WORD);
                SEFE_WORD:  nxt_state = SEFE_WDATA;
                SEFE_WDATA: nxt_state = SEFE_WDATA;
                SEFE_RDATA: nxt_state = master_ack_ff ? SEFE_RDATA : SEFE_IGNORE;
                default:    nxt_state = state_ff;
            endcase
        end
    end

    always_ff @(posedge i_link_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            state_ff <= SEFE_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // the fall that closes a Start carries no bit, so it must not count
    always_ff @(posedge i_link_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            fresh_ff <= 1'b0;
        end else if (start_ev) begin
            fresh_ff <= 1'b1;
        end else if (scl_fall) begin
            fresh_ff <= 1'b0;
        end
    end

    // bit counter, nine slots per byte; cleared by Start
    always_ff @(posedge i_link_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            bit_cnt_ff <= SEFE_BIT_CNT_RST;
        end else if (start_ev || stop_ev) begin
            bit_cnt_ff <= SEFE_BIT_CNT_RST;
        end else if (scl_fall && !fresh_ff && state_ff != SEFE_IDLE) begin
            bit_cnt_ff <= in_ack ? SEFE_BIT_CNT_RST : bit_cnt_ff + 4'h1;
        end
    end

    // receive shift, msb first, sampled on rising SCL
    always_ff @(posedge i_link_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            shift_ff <= SEFE_BYTE_RST;
        end else if (scl_rise && !in_ack && state_ff != SEFE_IDLE) begin
            shift_ff <= rx_byte;
        end
    end

    // capture address fields and data at the eighth rising edge
    always_ff @(posedge i_link_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            waddr_ff     <= SEFE_WADDR_RST;
            rw_ff        <= 1'b0;
            wdata_ff     <= SEFE_BYTE_RST;
            data_seen_ff <= 1'b0;
            addr_hit_ff  <= 1'b0;
        end else begin
            if (start_ev) begin
                data_seen_ff <= 1'b0;
            end
            if (byte_done) begin
                case (state_ff)
                    SEFE_DEV: begin
                        rw_ff <= sy.sda;
                        // held here: the shifter moves on a bit before the ack slot
                        addr_hit_ff <= addr_ok;
                        if (addr_ok && !sy.sda) begin
                            waddr_ff[SEFE_ADDR_W-1] <= shift_ff[SEFE_MSB_BIT-1];
                        end
                    end
                    SEFE_WORD: waddr_ff[SEFE_BYTE_BITS-1:0] <= rx_byte;
                    SEFE_WDATA: begin
                        wdata_ff     <= rx_byte;
                        data_seen_ff <= 1'b1;
                    end
                    default: waddr_ff <= waddr_ff;
                endcase
            end
        end
    end

    // master acknowledge after a read byte, sampled at ninth rising edge
    always_ff @(posedge i_link_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            master_ack_ff <= 1'b0;
        end else if (scl_rise && in_ack) begin
            master_ack_ff <= ~sy.sda;
        end
    end

    // sda drive: acknowledge and read data change only after falling SCL
    always_ff @(posedge i_link_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            sda_low_ff <= 1'b0;
            tx_ff      <= SEFE_BYTE_RST;
        end else if (start_ev || stop_ev) begin
            sda_low_ff <= 1'b0;
        end else if (scl_fall) begin
            if (bit_cnt_ff == SEFE_ACK_SLOT - 4'h1) begin
                // ack slot: receiver pulls low, transmitter lets go
                sda_low_ff <= ((state_ff == SEFE_DEV) && addr_hit_ff) ||
                              (state_ff == SEFE_WORD) ||
                              (state_ff == SEFE_WDATA);
            end else if (in_ack) begin
                if (nxt_state == SEFE_RDATA) begin
                    tx_ff      <= {i_rd_data[SEFE_BYTE_BITS-2:0], 1'b0};
                    sda_low_ff <= ~i_rd_data[SEFE_BYTE_BITS-1];
                end else begin
                    sda_low_ff <= 1'b0;
                end
            end else if (state_ff == SEFE_RDATA) begin
                tx_ff      <= {tx_ff[SEFE_BYTE_BITS-2:0], 1'b0};
                sda_low_ff <= ~tx_ff[SEFE_BYTE_BITS-1];
            end else begin
                sda_low_ff <= 1'b0;
            end
        end
    end

    // handshake toggles toward the array; standby level
    always_ff @(posedge i_link_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            wr_tog_ff   <= 1'b0;
            rd_tog_ff   <= 1'b0;
            stop_tog_ff <= 1'b0;
            standby_ff  <= 1'b1;
        end else begin
            if (byte_done && state_ff == SEFE_WDATA) begin
                wr_tog_ff <= ~wr_tog_ff;
            end
            if (scl_fall && in_ack && nxt_state == SEFE_RDATA) begin
                rd_tog_ff <= ~rd_tog_ff;
            end
            if (stop_ev && data_seen_ff) begin
                stop_tog_ff <= ~stop_tog_ff;                        // launches a write
            end
            if (start_ev) begin
                standby_ff <= 1'b0;
            end else if (stop_ev) begin
                standby_ff <= !data_seen_ff || busy_l;
            end else if (state_ff == SEFE_IDLE && !busy_l) begin
                standby_ff <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // outputs, each straight from a flip-flop in the link domain
    always_ff @(posedge i_link_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_sda_out     <= 1'b0;
            o_sda_oe      <= 1'b0;
            o_word_addr   <= SEFE_WADDR_RST;
            o_read_sel    <= 1'b0;
            o_wr_data     <= SEFE_BYTE_RST;
            o_wr_toggle   <= 1'b0;
            o_rd_toggle   <= 1'b0;
            o_stop_toggle <= 1'b0;
            o_standby     <= 1'b1;
        end else begin
            o_sda_out     <= 1'b0;            // open drain: only ever pulls low
            o_sda_oe      <= sda_low_ff;
            o_word_addr   <= waddr_ff;
            o_read_sel    <= rw_ff;
            o_wr_data     <= wdata_ff;
            o_wr_toggle   <= wr_tog_ff;
            o_rd_toggle   <= rd_tog_ff;
            o_stop_toggle <= stop_tog_ff;
            o_standby     <= standby_ff;
        end
    end
endmodule

// ---- sefe_top_chk.sv ----
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// protocol watcher on the pins of the front end, link clock domain only
module sefe_top_chk (
    input  wire logic i_link_clk,
    input  wire logic i_resetn,
    input  wire logic i_scl,
    input  wire logic i_sda,
    input  wire logic o_sda_out,
    input  wire logic o_sda_oe,
    input  wire logic i_write_busy,
    input  wire logic o_stop_toggle,
    input  wire logic o_standby
);
    logic       scl_ff;
    logic       sda_ff;
    logic [3:0] stop_age_ff;
    logic [3:0] drive_run_ff;
    logic [3:0] nxt_stop_age;
    logic [3:0] nxt_drive_run;
    wire        stop_now = i_scl && scl_ff && i_sda && !sda_ff;
    wire        scl_rise = i_scl && !scl_ff;
    // saturating age of the last stop, and run of rises with the line held
    assign nxt_stop_age  = stop_now ? 4'h0 : ((stop_age_ff == 4'hF) ? 4'hF : stop_age_ff + 4'h1);
    assign nxt_drive_run = !scl_rise ? drive_run_ff : (o_sda_oe ? drive_run_ff + 4'h1 : 4'h0);
    always_ff @(posedge i_link_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            scl_ff       <= 1'b1;
            sda_ff       <= 1'b1;
            stop_age_ff  <= 4'hF;
            drive_run_ff <= 4'h0;
        end else begin
            scl_ff       <= i_scl;
            sda_ff       <= i_sda;
            stop_age_ff  <= nxt_stop_age;
            drive_run_ff <= nxt_drive_run;
        end
    end
    default clocking cb @(posedge i_link_clk); endclocking
    default disable iff (!i_resetn);
    sequence start_ev;
        i_scl && $past(i_scl) && $fell(i_sda);
    endsequence
    sequence stop_ev;
        i_scl && $past(i_scl) && $rose(i_sda);
    endsequence
    a_drive_low_only: assert property (o_sda_oe |-> !o_sda_out)
        else $error("data line driven high");
    a_oe_rise_low: assert property ($rose(o_sda_oe) |-> !i_scl && !$past(i_scl))
        else $error("drive began while clock high");
    a_oe_fall_low: assert property ($fell(o_sda_oe) |-> !i_scl)
        else $error("release while clock high");
    a_oe_holds_high: assert property (o_sda_oe && $rose(i_scl) |-> o_sda_oe [*6])
        else $error("drive dropped in high phase");
    a_ack_not_busy: assert property ($rose(o_sda_oe) |-> !i_write_busy)
        else $error("answer given during write");
    a_start_wakes: assert property (start_ev |-> ##[1:6] !o_standby)
        else $error("start left standby set");
    a_stop_standby: assert property (stop_ev |-> ##6 (o_standby || o_stop_toggle != $past(o_stop_toggle, 6)))
        else $error("stop did not return to standby");
    a_launch_at_stop: assert property ($changed(o_stop_toggle) |-> stop_age_ff < 4'h8)
        else $error("write launch without stop");
    a_release_nine: assert property (drive_run_ff <= 4'h9)
        else $error("line held over nine clocks");
endmodule

bind sefe_top sefe_top_chk sefe_top_chk_inst (.i_link_clk(i_link_clk), .i_resetn(i_resetn), .i_scl(i_scl),
    .i_sda(i_sda), .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe), .i_write_busy(i_write_busy),
    .o_stop_toggle(o_stop_toggle), .o_standby(o_standby));

// ---- sefe_host.sv ----
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// behavioural bus master; data has a pull-up, so release means not pulling
module sefe_host (
    input  wire logic i_clk,
    input  wire logic i_sda,
    output logic      o_scl,
    output logic      o_sda_low
);
    int slow = 0; // extra low-phase ticks for a slow master
    initial begin
        o_scl     = 1'b1;
        o_sda_low = 1'b0;
    end
    task automatic tick();
        repeat (4) @(negedge i_clk);
    endtask
    // data changes only with clock low, sampled mid high phase
    task automatic bit_cycle(input logic b, output logic r);
        o_scl = 1'b0;
        tick();
        repeat (slow) tick();
        o_sda_low = ~b;
        tick();
        o_scl = 1'b1;
        tick();
        r = i_sda;
        tick();
    endtask
    task automatic start();
        o_scl = 1'b0;
        tick();
        o_sda_low = 1'b0;
        tick();
        o_scl = 1'b1;
        tick();
        o_sda_low = 1'b1;
        tick();
    endtask
    task automatic stop();
        o_scl = 1'b0;
        tick();
        o_sda_low = 1'b1;
        tick();
        o_scl = 1'b1;
        tick();
        o_sda_low = 1'b0;
        tick();
    endtask
    // eight bits msb first, then the answer slot
    task automatic xfer(input logic [7:0] d, input logic ack_in, output logic [7:0] q, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            bit_cycle(d[i], q[i]);
        end
        bit_cycle(ack_in, ack);
    endtask
endmodule

// ---- sefe_top_tb.sv ----
`timescale 1ns/1ps
module sefe_top_tb;
    import sefe_pkg::*;
    localparam logic [3:0] TID = 4'h5; // arbitrary identifier value
    logic       clk, link_clk, resetn, scl, sda_low, sel_hi, sel_lo, busy, a;
    logic       sda_out, sda_oe, read_sel, wr_tog, rd_tog, stop_tog, standby;
    logic [7:0] rd_data, wr_data, q, w;
    logic [8:0] word_addr;
    logic [31:0] seed;
    logic [7:0] exp_q[$];
    int         err_count, cmp_count, wr_n, rd_n, stop_n, n;
    wire        sda = ~(sda_low | (sda_oe & ~sda_out)); // pull-up wins when nobody pulls
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial begin
        link_clk = 1'b0;
        #13;
        forever #40 link_clk = ~link_clk;
    end
    sefe_top #(.TYPE_ID(TID)) sefe_top_inst (.i_clk(clk), .i_resetn(resetn), .i_link_clk(link_clk), .i_scl(scl),
        .i_sda(sda), .o_sda_out(sda_out), .o_sda_oe(sda_oe), .i_hw_select_hi(sel_hi), .i_hw_select_lo(sel_lo),
        .i_write_busy(busy), .i_rd_data(rd_data), .o_word_addr(word_addr), .o_read_sel(read_sel),
        .o_wr_data(wr_data), .o_wr_toggle(wr_tog), .o_rd_toggle(rd_tog), .o_stop_toggle(stop_tog),
        .o_standby(standby));
    sefe_host sefe_host_inst (.i_clk(link_clk), .i_sda(sda), .o_scl(scl), .o_sda_low(sda_low));
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // reference answer to an address byte
    function automatic logic hit(input logic [7:0] b);
        return b[7:4] == TID && b[3] == sel_hi && b[2] == sel_lo && !busy;
    endfunction
    task automatic chk(input logic [8:0] got, input logic [8:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic send(input logic [7:0] b, input logic exp_ack);
        sefe_host_inst.xfer(b, 1'b1, q, a);
        chk(9'(a), {8'h00, ~exp_ack});
    endtask
    task automatic finish_stop();
        sefe_host_inst.stop();
        repeat (8) @(negedge link_clk);
        chk(9'(standby), 9'h001);
    endtask
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        #400000;
        err_count++;
        complete_run();
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        {resetn, sel_hi, sel_lo, busy} = 4'h0;
        rd_data = 8'h00;
        seed = 32'hB0FB;
        {err_count, cmp_count, wr_n, rd_n, stop_n} = '0;
        repeat (4) @(negedge link_clk);
        resetn = 1'b1;
        repeat (4) @(negedge link_clk);
        chk(9'(standby), 9'h001);
        send({TID, 4'h0}, 1'b0);
        seed = lfsr(seed);
        @(negedge clk);
        {sel_hi, sel_lo} = seed[1:0];
        // every select pair, then a wrong identifier, then a busy device
        for (int i = 0; i < 6; i++) begin
            w = (i == 4) ? {TID ^ 4'h8, sel_hi, sel_lo, 2'h0} : (i == 5) ? {TID, sel_hi, sel_lo, 2'h0} : {TID, i[1:0], 2'h0};
            @(negedge clk);
            busy = (i == 5);
            sefe_host_inst.start();
            chk(9'(standby), 9'h000);
            send(w, hit(w));
            finish_stop();
        end
        @(negedge clk);
        busy = 1'b0;
        // write: msb from address byte, two data bytes back to back
        seed = lfsr(seed);
        sefe_host_inst.start();
        send({TID, sel_hi, sel_lo, 2'h2}, 1'b1);
        send(seed[7:0], 1'b1);
        chk(word_addr, {1'b1, seed[7:0]});
        chk(9'(read_sel), 9'h000);
        for (int i = 0; i < 2; i++) begin
            seed = lfsr(seed);
            send(seed[15:8], 1'b1);
            wr_n++;
            chk(9'(wr_data), 9'(seed[15:8]));
            chk(9'(wr_tog), 9'(wr_n[0]));
        end
        sefe_host_inst.stop();
        stop_n++;
        repeat (8) @(negedge link_clk);
        chk(9'(stop_tog), 9'(stop_n[0]));
        // random read through a repeated start, slow master, nack at the end
        sefe_host_inst.slow = 2;
        sefe_host_inst.start();
        send({TID, sel_hi, sel_lo, 2'h0}, 1'b1);
        send(seed[23:16], 1'b1);
        @(negedge clk);
        rd_data = seed[31:24];
        exp_q.push_back(seed[31:24]);
        sefe_host_inst.start();
        send({TID, sel_hi, sel_lo, 2'h1}, 1'b1);
        chk(9'(read_sel), 9'h001);
        chk(word_addr, {1'b0, seed[23:16]});
        for (int i = 0; i < 2; i++) begin
            sefe_host_inst.xfer(8'hFF, i[0], q, a);
            rd_n++;
            chk(9'(q), 9'(exp_q.pop_front()));
            chk(9'(rd_tog), 9'(rd_n[0]));
            @(negedge clk);
            rd_data = ~rd_data;
            exp_q.push_back(rd_data);
        end
        sefe_host_inst.slow = 0;
        finish_stop();
        // broken read: dummy clocks until the line is let go
        @(negedge clk);
        rd_data = 8'h00;
        sefe_host_inst.start();
        send({TID, sel_hi, sel_lo, 2'h1}, 1'b1);
        a = 1'b0;
        n = 0;
        while (a !== 1'b1 && n < 12) begin
            sefe_host_inst.bit_cycle(1'b1, a);
            n++;
        end
        chk(9'(n), 9'h009);
        sefe_host_inst.start();
        send({TID, sel_hi, sel_lo, 2'h0}, 1'b1);
        finish_stop();
        complete_run();
    end
endmodule
